//--- src/csb_defines.svh
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
// =====================================================================
// Timing.
`define CSB_CLK_NS          40
`define CSB_PD_WAIT_NS      150000
`define CSB_PD_WAIT_CYC     ((`CSB_PD_WAIT_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS)
`define CSB_SCLK_NS         320
`define CSB_SCLK_HALF       (`CSB_SCLK_NS / `CSB_CLK_NS / 2)
// =====================================================================
// Status byte layout.
`define CSB_BIT_READY       7
`define CSB_STATE_HI        6
`define CSB_STATE_LO        4
`define CSB_CNT_HI          3
`define CSB_CNT_SAT         4'hF
`define CSB_ST_IDLE         3'h0
`define CSB_ST_RX           3'h1
`define CSB_ST_TX           3'h2
`define CSB_ST_SYNTH_ON     3'h3
`define CSB_ST_CALIBRATE    3'h4
`define CSB_ST_SETTLING     3'h5
`define CSB_ST_RX_OVERRUN   3'h6
`define CSB_ST_TX_UNDERRUN  3'h7
// =====================================================================
// Host register map and fields.
`define CSB_REG_CMD         5'h00
`define CSB_REG_STAT        5'h04
`define CSB_REG_IRQ         5'h08
`define CSB_REG_MASK        5'h0C
`define CSB_CMD_KEEP        8
`define CSB_CMD_NOPOLL      9
`define CSB_IRQ_DONE        0
`define CSB_IRQ_OVERRUN     1
`define CSB_IRQ_UNDERRUN    2
`define CSB_IRQ_W           3
`define CSB_RESET_MISO      1'b1
`endif

//--- src/csb_pkg.sv
package csb_pkg;
`include "csb_defines.svh"
   typedef logic [2:0] csb_state_t;
   typedef enum logic [3:0] {
      HST_IDLE  = 4'b0001,
      HST_READY = 4'b0010,
      HST_LOW   = 4'b0100,
      HST_HIGH  = 4'b1000
   } csb_host_e;

   function automatic logic [3:0] csb_sat4(input logic [6:0] n);
      csb_sat4 = (n > 7'(`CSB_CNT_SAT)) ? `CSB_CNT_SAT : n[3:0];
   endfunction

   function automatic logic [2:0] csb_field_state(input logic [7:0] b);
      csb_field_state = b[`CSB_STATE_HI:`CSB_STATE_LO];
   endfunction
endpackage

//--- src/csb_link_if.sv
`timescale 1ns/1ps
interface csb_link_if;
   logic select_low;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso_level;
   // Serial output floats high while the device does not drive it.
   assign miso_level = miso_oe ? miso_o : 1'b1;
   modport dev (input select_low, input sclk, input mosi, output miso_o, output miso_oe);
   modport host (output select_low, output sclk, output mosi, input miso_level);
endinterface

//--- src/csb_device.sv
`timescale 1ns/1ps
`include "csb_defines.svh"
// =====================================================================
// Summary of operation
// - Status byte shifts out with every byte.
// - Bit 7 low once oscillator ready.
// - Host waits for ready before clocking.
// - Bits 6:4 give the main state.
// - Transitional states may report idle code.
// - Host reads, then flushes after overrun.
// - Host flushes after transmit underrun.
// - Read access: low nibble counts received bytes.
// - Write access: low nibble counts free bytes.
// - Nibble saturates at fifteen.
// - Idle powers only oscillator and core.
// - Host reconfigures only while idle.
// - Without polling, host waits 150 us.
// - Host limits serial clock rate.
// - All bytes travel MSB first.
// - Each transaction opens with header byte.
module csb_device
   import csb_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   csb_link_if.dev         link,
   input  wire logic       osc_stable,
   input  wire csb_state_t main_state,
   input  wire logic       transit_idle,
   input  wire logic [6:0] rx_avail,
   input  wire logic [6:0] tx_free,
   output logic [7:0]      byte_data,
   output logic            byte_valid,
   output logic            byte_header,
   output logic            byte_rw,
   output logic            analog_power_en
);

   // ==================================================================
   // Input synchronisers.
   // The link pins come from another clock domain. Stage 0 of each
   // chain feeds only stage 1; edges are found between stages 1 and 2.
   logic [1:0] sel_sync_reg;
   logic [2:0] sclk_sync_reg;
   logic [1:0] mosi_sync_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sel_sync_reg  <= 2'h3;
         sclk_sync_reg <= 3'h0;
         mosi_sync_reg <= 2'h0;
      end else if (clk_en) begin
         sel_sync_reg  <= {sel_sync_reg[0], link.select_low};
         sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
         mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
      end
   end

   logic sel_active;
   logic sclk_level;
   logic sclk_rise;
   logic sclk_fall;
   logic mosi_bit;

   assign sel_active = !sel_sync_reg[1];
   assign sclk_level = sclk_sync_reg[1];
   assign sclk_rise  = sclk_sync_reg[1] && !sclk_sync_reg[2];
   assign sclk_fall  = !sclk_sync_reg[1] && sclk_sync_reg[2];
   assign mosi_bit   = mosi_sync_reg[1];

   // ==================================================================
   // Live status byte.
   logic       rw_reg;
   csb_state_t shown_state;
   logic [3:0] fifo_nibble;
   logic [7:0] status_live;

   always_comb begin
      shown_state = main_state;
      if (transit_idle && (main_state == `CSB_ST_CALIBRATE ||
                           main_state == `CSB_ST_SETTLING)) begin
         shown_state = `CSB_ST_IDLE;
      end
   end

   // The count is picked per bit so that the header's own direction
   // bit, taken at its first edge, already governs bits 3:0.
   assign fifo_nibble = rw_reg ? csb_sat4(rx_avail)
                               : csb_sat4(tx_free);
   assign status_live = {!osc_stable,
                         shown_state,
                         fifo_nibble};

   // ==================================================================
   // Receive shifter and byte framing.
   logic [2:0] bit_cnt_reg;
   logic [6:0] rx_shift_reg;
   logic       hdr_pend_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bit_cnt_reg  <= 3'h0;
         rx_shift_reg <= 7'h00;
         hdr_pend_reg <= 1'b1;
         rw_reg       <= 1'b0;
      end else if (clk_en) begin
         if (!sel_active) begin
            // Raising select cancels a partial byte.
            bit_cnt_reg  <= 3'h0;
            hdr_pend_reg <= 1'b1;
         end else if (sclk_rise) begin
            rx_shift_reg <= {rx_shift_reg[5:0], mosi_bit};
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h0 && hdr_pend_reg) begin
               rw_reg <= mosi_bit;
            end
            if (bit_cnt_reg == 3'h7) begin
               hdr_pend_reg <= 1'b0;
            end
         end
      end
   end

   // ==================================================================
   // Received byte report to the core.
   logic [7:0] byte_data_reg;
   logic       byte_valid_reg;
   logic       byte_header_reg;
   logic       byte_rw_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         byte_data_reg   <= 8'h00;
         byte_valid_reg  <= 1'b0;
         byte_header_reg <= 1'b0;
         byte_rw_reg     <= 1'b0;
      end else if (clk_en) begin
         byte_valid_reg <= sel_active && sclk_rise && bit_cnt_reg == 3'h7;
         if (sel_active && sclk_rise && bit_cnt_reg == 3'h7) begin
            byte_data_reg   <= {rx_shift_reg, mosi_bit};
            byte_header_reg <= hdr_pend_reg;
            byte_rw_reg     <= rw_reg;
         end
      end
   end

   // ==================================================================
   // Serial output.
   logic miso_reg;
   logic miso_oe_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         miso_reg    <= `CSB_RESET_MISO;
         miso_oe_reg <= 1'b0;
      end else if (clk_en) begin
         miso_oe_reg <= sel_active;
         if (!sel_active) begin
            miso_reg <= `CSB_RESET_MISO;
         end else if (sclk_fall) begin
            // After eight rises the count wraps and bit 7 follows.
            miso_reg <= status_live[~bit_cnt_reg];
         end else if (bit_cnt_reg == 3'h0 && !sclk_level) begin
            // Between bytes the ready flag tracks the oscillator, so
            // the host sees it fall without clocking.
            miso_reg <= status_live[`CSB_BIT_READY];
         end
      end
   end

   // ==================================================================
   // Power control.
   logic analog_power_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         analog_power_reg <= 1'b0;
      end else if (clk_en) begin
         analog_power_reg <= main_state != `CSB_ST_IDLE;
      end
   end

   assign link.miso_o     = miso_reg;
   assign link.miso_oe    = miso_oe_reg;
   assign byte_data       = byte_data_reg;
   assign byte_valid      = byte_valid_reg;
   assign byte_header     = byte_header_reg;
   assign byte_rw         = byte_rw_reg;
   assign analog_power_en = analog_power_reg;

endmodule // csb_device

//--- src/csb_host.sv
`timescale 1ns/1ps
`include "csb_defines.svh"
module csb_host
   import csb_pkg::*;
#(
   parameter int SCLK_HALF   = `CSB_SCLK_HALF,
   parameter int PD_WAIT_CYC = `CSB_PD_WAIT_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   csb_link_if.host         link
);

   // ==================================================================
   // Serial input synchroniser.
   logic [1:0] miso_sync_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         miso_sync_reg <= 2'h3;
      end else if (clk_en) begin
         miso_sync_reg <= {miso_sync_reg[0], link.miso_level};
      end
   end

   // ==================================================================
   // Bus slave.
   csb_host_e  st_reg;
   logic       wait_reg;
   logic [31:0] rdata_reg;
   logic       busy_write;
   logic       cmd_go;
   logic       irq_rd;

   assign busy_write = avs_write && avs_address == `CSB_REG_CMD && st_reg != HST_IDLE;
   assign cmd_go     = avs_write && !wait_reg && avs_address == `CSB_REG_CMD;
   assign irq_rd     = avs_read && !wait_reg && avs_address == `CSB_REG_IRQ;

   logic [7:0] status_reg;
   logic       sel_low_reg;
   logic [`CSB_IRQ_W-1:0] irq_stat_reg;
   logic [`CSB_IRQ_W-1:0] irq_mask_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wait_reg     <= 1'b1;
         rdata_reg    <= 32'h0000_0000;
         irq_mask_reg <= '0;
      end else if (clk_en) begin
         if (!wait_reg) begin
            wait_reg <= 1'b1;
            if (avs_write && avs_address == `CSB_REG_MASK) begin
               irq_mask_reg <= avs_writedata[`CSB_IRQ_W-1:0];
            end
         end else if ((avs_read || avs_write) && !busy_write) begin
            wait_reg <= 1'b0;
            unique case (avs_address)
               `CSB_REG_STAT: rdata_reg <= {20'h0_0000,
                                  csb_field_state(status_reg) == `CSB_ST_IDLE,
                                  !sel_low_reg, st_reg != HST_IDLE, 1'b0, status_reg};
               `CSB_REG_IRQ:  rdata_reg <= {29'h0000_0000, irq_stat_reg};
               `CSB_REG_MASK: rdata_reg <= {29'h0000_0000, irq_mask_reg};
               default:       rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==================================================================
   // Byte engine.
   logic [7:0]  tx_shift_reg;
   logic [7:0]  rx_shift_reg;
   logic [2:0]  bit_cnt_reg;
   logic [15:0] div_cnt_reg;
   logic [15:0] wait_cnt_reg;
   logic        keep_reg;
   logic        nopoll_reg;
   logic        sclk_reg;
   logic        mosi_reg;
   logic        done;
   logic [7:0]  rx_next;

   assign rx_next = {rx_shift_reg[6:0], miso_sync_reg[1]};
   assign done    = st_reg == HST_HIGH && div_cnt_reg == 16'(SCLK_HALF - 1) &&
                    bit_cnt_reg == 3'h7;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg       <= HST_IDLE;
         tx_shift_reg <= 8'h00;
         rx_shift_reg <= 8'h00;
         status_reg   <= 8'hFF;
         bit_cnt_reg  <= 3'h0;
         div_cnt_reg  <= 16'h0000;
         wait_cnt_reg <= 16'h0000;
         keep_reg     <= 1'b0;
         nopoll_reg   <= 1'b0;
         sel_low_reg  <= 1'b1;
         sclk_reg     <= 1'b0;
         mosi_reg     <= 1'b0;
      end else if (clk_en) begin
         unique case (st_reg)
            HST_IDLE: if (cmd_go) begin
               tx_shift_reg <= avs_writedata[7:0];
               keep_reg     <= avs_writedata[`CSB_CMD_KEEP];
               nopoll_reg   <= avs_writedata[`CSB_CMD_NOPOLL];
               bit_cnt_reg  <= 3'h0;
               div_cnt_reg  <= 16'h0000;
               wait_cnt_reg <= 16'h0000;
               mosi_reg     <= avs_writedata[7];
               sel_low_reg  <= 1'b0;
               // A fresh select must first see the device ready.
               st_reg       <= sel_low_reg ? HST_READY : HST_LOW;
            end
            HST_READY: begin
               wait_cnt_reg <= wait_cnt_reg + 16'h0001;
               if (nopoll_reg ? wait_cnt_reg == 16'(PD_WAIT_CYC - 1)
                              : !miso_sync_reg[1]) begin
                  st_reg <= HST_LOW;
               end
            end
            HST_LOW: begin
               div_cnt_reg <= div_cnt_reg + 16'h0001;
               if (div_cnt_reg == 16'(SCLK_HALF - 1)) begin
                  div_cnt_reg <= 16'h0000;
                  sclk_reg    <= 1'b1;
                  st_reg      <= HST_HIGH;
               end
            end
            HST_HIGH: begin
               div_cnt_reg <= div_cnt_reg + 16'h0001;
               if (div_cnt_reg == 16'(SCLK_HALF - 1)) begin
                  // Sampling at the end of the high phase leaves the
                  // device's output and both synchronisers time to settle.
                  div_cnt_reg  <= 16'h0000;
                  sclk_reg     <= 1'b0;
                  rx_shift_reg <= rx_next;
                  bit_cnt_reg  <= bit_cnt_reg + 3'h1;
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                  mosi_reg     <= tx_shift_reg[6];
                  st_reg       <= HST_LOW;
                  if (done) begin
                     status_reg  <= rx_next;
                     sel_low_reg <= !keep_reg;
                     st_reg      <= HST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ==================================================================
   // Interrupts. A new event wins over the clear of the same read.
   logic [`CSB_IRQ_W-1:0] irq_ev;
   logic [`CSB_IRQ_W-1:0] irq_next;
   logic                  irq_reg;

   always_comb begin
      irq_ev = '0;
      irq_ev[`CSB_IRQ_DONE]     = done;
      irq_ev[`CSB_IRQ_OVERRUN]  = done &&
         csb_field_state(rx_next) == `CSB_ST_RX_OVERRUN;
      irq_ev[`CSB_IRQ_UNDERRUN] = done &&
         csb_field_state(rx_next) == `CSB_ST_TX_UNDERRUN;
      irq_next = (irq_rd ? '0 : irq_stat_reg) | irq_ev;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq_stat_reg <= '0;
         irq_reg      <= 1'b0;
      end else if (clk_en) begin
         irq_stat_reg <= irq_next;
         irq_reg      <= |(irq_next & irq_mask_reg);
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign irq             = irq_reg;
   assign link.select_low = sel_low_reg;
   assign link.sclk       = sclk_reg;
   assign link.mosi       = mosi_reg;

endmodule // csb_host

//--- verification/csb_link_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// Link checker: watches only the wires between the two ends.
module csb_link_asserts (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic select_low,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso_level
);
   logic       sclk_reg;
   logic       seen_reg;
   logic [2:0] rise_reg;

   always_ff @(posedge core_clk) begin
      sclk_reg <= sclk;
   end

   // Cleared while deselected, so only the first clock of a frame is judged.
   always_ff @(posedge core_clk) begin
      if (!reset_n || select_low) begin
         seen_reg <= 1'b0;
      end else if (sclk && !sclk_reg) begin
         seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || select_low) begin
         rise_reg <= 3'h0;
      end else if (sclk && !sclk_reg) begin
         rise_reg <= rise_reg + 3'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_idle_clock_low: assert property (select_low |-> !sclk)
      else $error("serial clock active outside a frame");
   a_frame_whole_bytes: assert property ($rose(select_low) |-> rise_reg == 3'h0)
      else $error("frame closed inside a byte");
   a_ready_before_clk: assert property (sclk && !sclk_reg && !seen_reg |-> !miso_level)
      else $error("first clock edge before the ready flag was low");
   a_clk_high_len: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
      else $error("clock high phase not four cycles");
   a_clk_low_len: assert property ($fell(sclk) |-> !sclk[*4])
      else $error("clock low phase shorter than four cycles");
   a_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi)[*4])
      else $error("serial input moved around the sampling edge");
   a_miso_steady: assert property ($rose(sclk) |-> ##1 $stable(miso_level)[*3])
      else $error("serial output moved while the clock was high");
   a_release_miso: assert property (select_low[*5] |-> !miso_oe)
      else $error("serial output driven while deselected");
   a_drive_miso: assert property (!select_low[*5] |-> miso_oe)
      else $error("serial output not driven while selected");
   a_miso_rest_high: assert property (!miso_oe |-> miso_o)
      else $error("serial output register not high while released");
endmodule // csb_link_asserts

//--- verification/tb_spi_chip_status_byte.sv
`timescale 1ns/1ps
`include "csb_defines.svh"
// =====================================================================
// Bench: software drives the host end, the device end sees a fake radio.
module tb_spi_chip_status_byte;
   import csb_pkg::*;
   localparam int PDW = 20;
   logic        core_clk, reset_n, osc_stable, transit_idle, avs_read, avs_write;
   logic        avs_waitrequest, irq, byte_valid, byte_header, byte_rw, analog_power_en;
   csb_state_t  main_state;
   logic [6:0]  rx_avail, tx_free;
   logic [4:0]  avs_address;
   logic [7:0]  byte_data;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int          err_count, checks;
   int          cyc = 0, sel_cyc = 0, gap = 0, pulses = 0;
   logic        armed = 1'b0;

   csb_link_if i_csb_link_if ();
   csb_device i_csb_device (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
      .link(i_csb_link_if.dev), .osc_stable(osc_stable), .main_state(main_state),
      .transit_idle(transit_idle), .rx_avail(rx_avail), .tx_free(tx_free),
      .byte_data(byte_data), .byte_valid(byte_valid), .byte_header(byte_header),
      .byte_rw(byte_rw), .analog_power_en(analog_power_en));
   csb_host #(.SCLK_HALF(4), .PD_WAIT_CYC(PDW)) i_csb_host (.core_clk(core_clk),
      .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .link(i_csb_link_if.host));
   csb_link_asserts i_csb_link_asserts (.core_clk(core_clk), .reset_n(reset_n),
      .select_low(i_csb_link_if.select_low), .sclk(i_csb_link_if.sclk),
      .mosi(i_csb_link_if.mosi), .miso_o(i_csb_link_if.miso_o),
      .miso_oe(i_csb_link_if.miso_oe), .miso_level(i_csb_link_if.miso_level));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Cycles from the fall of select to the first clock high of the frame.
   // Received byte reports are counted here as well.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (byte_valid) begin
         pulses <= pulses + 1;
      end
      if (i_csb_link_if.select_low) begin
         sel_cyc <= cyc;
         armed   <= 1'b1;
      end else if (armed && i_csb_link_if.sclk) begin
         gap   <= cyc - sel_cyc;
         armed <= 1'b0;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A held command write can stall, so the wait is long but bounded.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_read      <= !wr;
      avs_write     <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 300);
      if (n >= 300) begin
         err_count++;
         $display("MISMATCH at %0t: bus cycle never answered", $time);
      end
      d = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wait_done(input logic [7:0] b);
      int n;
      n = 0;
      do begin
         bus(1'b0, `CSB_REG_STAT, 32'h0000_0000, rd);
         n++;
      end while (rd[9] !== 1'b0 && n < 100);
      if (n >= 100) begin
         err_count++;
         $display("MISMATCH at %0t: transfer never finished", $time);
      end
      chk({24'h00_0000, byte_data}, {24'h00_0000, b});
   endtask

   task automatic send(input logic [7:0] b, input logic keep, input logic np);
      bus(1'b1, `CSB_REG_CMD, {22'h00_0000, np, keep, b}, rd);
      wait_done(b);
   endtask

   function automatic logic [31:0] st(input logic [2:0] s, input logic [6:0] n);
      // Bit 11 of the status word flags a captured idle code.
      st = {20'h0_0000, s == 3'h0, 3'h0, 1'b0, s, (n > 7'h0F) ? 4'hF : n[3:0]};
   endfunction

   initial begin
      {reset_n, osc_stable, transit_idle, avs_read, avs_write} = 5'h00;
      {main_state, rx_avail, tx_free, avs_address, avs_writedata} = '0;
      {err_count, checks} = '0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, `CSB_REG_STAT, 32'h0000_0000, rd);
      chk(rd, 32'h0000_00FF);
      bus(1'b0, `CSB_REG_MASK, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      bus(1'b1, 5'h10, 32'hFFFF_FFFF, rd);
      bus(1'b0, 5'h10, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      // The oscillator is held off so the host must stall before clocking.
      main_state <= `CSB_ST_RX;
      rx_avail   <= 7'h09;
      bus(1'b1, `CSB_REG_CMD, 32'h0000_00A5, rd);
      repeat (40) @(posedge core_clk);
      chk({30'h0, i_csb_link_if.select_low, i_csb_link_if.sclk}, 32'h0000_0000);
      osc_stable <= 1'b1;
      wait_done(8'hA5);
      chk(rd, st(3'h1, 7'h09));
      chk({31'h0, gap >= 40}, 32'h0000_0001);
      bus(1'b0, `CSB_REG_IRQ, 32'h0000_0000, rd);
      bus(1'b1, `CSB_REG_MASK, 32'h0000_0006, rd);
      for (int i = 0; i < 8; i++) begin
         main_state <= 3'(i);
         rx_avail   <= 7'(i * 3);
         tx_free    <= 7'(24 - i * 3);
         send({i[0], 7'h3F}, 1'b0, 1'b0);
         chk(rd, st(3'(i), i[0] ? 7'(i * 3) : 7'(24 - i * 3)));
         chk({31'h0, byte_rw}, {31'h0, i[0]});
         chk({31'h0, analog_power_en}, {31'h0, i != 0});
         chk({31'h0, irq}, {31'h0, i >= 6});
         bus(1'b0, `CSB_REG_IRQ, 32'h0000_0000, rd);
         chk(rd, {29'h0, i == 7, i == 6, 1'b1});
         chk({31'h0, irq}, 32'h0000_0000);
      end
      transit_idle <= 1'b1;
      for (int j = 4; j < 6; j++) begin
         main_state <= 3'(j);
         rx_avail   <= 7'h02;
         send(8'hBF, 1'b0, 1'b0);
         chk(rd, st(3'h0, 7'h02));
      end
      // The data byte has bit 7 set, yet the count must follow the header.
      transit_idle <= 1'b0;
      main_state   <= `CSB_ST_TX;
      tx_free      <= 7'h03;
      rx_avail     <= 7'h0E;
      send(8'h7F, 1'b1, 1'b0);
      chk({31'h0, rd[10]}, 32'h0000_0001);
      chk({31'h0, byte_header}, 32'h0000_0001);
      send(8'hC3, 1'b0, 1'b0);
      chk(rd, st(3'h2, 7'h03));
      chk({31'h0, byte_header}, 32'h0000_0000);
      send(8'h3F, 1'b0, 1'b1);
      chk({31'h0, gap >= PDW}, 32'h0000_0001);
      chk(32'(pulses), 32'h0000_000E);
      tally_and_finish();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // tb_spi_chip_status_byte
